// ==== verilog/eii_consts.vh ====
// Constants for the external interrupt inputs block
`ifndef EII_CONSTS_VH
`define EII_CONSTS_VH

`define EII_CFG_ADDR      8'hDE
`define EII_CFG_RESET     8'h00
`define EII_A_SEL_LSB     0
`define EII_A_SEL_MSB     2
`define EII_A_POL_BIT     3
`define EII_B_SEL_LSB     4
`define EII_B_SEL_MSB     6
`define EII_B_POL_BIT     7
`define EII_TMR_CTL_ADDR   8'h88
`define EII_TMR_CTL_RESET  8'h00
`define EII_TMR_CTL_A_EDGE 0
`define EII_TMR_CTL_A_PEND 1
`define EII_TMR_CTL_B_EDGE 2
`define EII_TMR_CTL_B_PEND 3
`define EII_PORT_WIDTH    8
`define EII_SEL_WIDTH     3

`endif

// ==== verilog/eii_channel.v ====
// One external interrupt channel: pin pick, sync, pending flag
`timescale 1ns/1ps
module eii_channel #(
   parameter PORT_WIDTH = 8,
   parameter SEL_WIDTH  = 3
) (
   input  wire                  ref_clk_i,
   input  wire                  reset_i,
   input  wire [PORT_WIDTH-1:0] port_pins_i,
   input  wire [SEL_WIDTH-1:0]  pin_select_i,
   input  wire                  polarity_i,
   input  wire                  edge_select_i,
   input  wire                  vector_ack_i,
   input  wire                  sw_write_i,
   input  wire                  sw_value_i,
   output reg                   pending_o
);

   reg        sync_meta;
   reg        sync_pin;
   reg        prev_active;
   reg  [1:0] sync_fill;
   wire       active;
   wire       edge_seen;
   reg        next_pending;

   ////////////////////////////////////////////////////////////////////////
   // pin index pick; read only, never drives the pin
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync_meta   <= 1'b0;
         sync_pin    <= 1'b0;
         prev_active <= 1'b1;
         sync_fill   <= 2'b00;
      end else begin
         sync_meta   <= port_pins_i[pin_select_i];
         sync_pin    <= sync_meta;
         sync_fill   <= {sync_fill[0], 1'b1};
         // Until the sync stages hold real pin values, treat as active
         // so that no false edge follows reset
         prev_active <= sync_fill[1] ? active : 1'b1;
      end
   end

   assign active    = polarity_i ? sync_pin : ~sync_pin;
   assign edge_seen = active & ~prev_active;

   ////////////////////////////////////////////////////////////////////////
   always @* begin
      next_pending = pending_o;
      // edge mode when select is 1
      if (edge_select_i) begin
         if (sw_write_i)
            next_pending = sw_value_i;
         if (vector_ack_i)
            next_pending = 1'b0;
         // Set wins over any clear in the same cycle
         if (edge_seen)
            next_pending = 1'b1;
      end else begin
         // level mode flag follows input
         // Reset values of the sync flops are not pin levels
         next_pending = active & sync_fill[1];
      end
   end

   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i)
         pending_o <= 1'b0;
      else
         pending_o <= next_pending;
   end

endmodule

// ==== verilog/eii_top.v ====
// External interrupt inputs: config registers and two channels
`timescale 1ns/1ps
`include "eii_consts.vh"
module eii_top #(
   parameter PORT_WIDTH = `EII_PORT_WIDTH,
   parameter SEL_WIDTH  = `EII_SEL_WIDTH
) (
   input  wire                  ref_clk_i,
   input  wire                  reset_i,
   input  wire [PORT_WIDTH-1:0] port_pins_i,
   input  wire [7:0]            sfr_addr_i,
   input  wire [7:0]            sfr_wdata_i,
   input  wire                  sfr_wr_i,
   input  wire                  sfr_rd_i,
   input  wire                  vector_a_i,
   input  wire                  vector_b_i,
   output reg  [7:0]            sfr_rdata_o,
   output wire                  irq_a_request_o,
   output wire                  irq_b_request_o
);

   reg  [7:0] ext_irq_pin_polarity_config;
   reg        irq_a_edge_select;
   reg        irq_b_edge_select;
   wire       irq_a_pending;
   wire       irq_b_pending;
   wire       cfg_hit;
   wire       tmr_ctl_hit;
   wire [7:0] timer_control_reg;
   reg  [7:0] next_rdata;

   assign cfg_hit  = sfr_addr_i == `EII_CFG_ADDR;
   assign tmr_ctl_hit = sfr_addr_i == `EII_TMR_CTL_ADDR;

   ////////////////////////////////////////////////////////////////////////
   // Configuration and trigger-type storage
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ext_irq_pin_polarity_config <= `EII_CFG_RESET;
         irq_a_edge_select           <= 1'b0;
         irq_b_edge_select           <= 1'b0;
      end else if (sfr_wr_i) begin
         if (cfg_hit)
            ext_irq_pin_polarity_config <= sfr_wdata_i;
         if (tmr_ctl_hit) begin
            irq_a_edge_select <= sfr_wdata_i[`EII_TMR_CTL_A_EDGE];
            irq_b_edge_select <= sfr_wdata_i[`EII_TMR_CTL_B_EDGE];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two identical independent channels
   eii_channel #(
      .PORT_WIDTH (PORT_WIDTH),
      .SEL_WIDTH  (SEL_WIDTH)
   ) u_chan_a (
      .ref_clk_i     (ref_clk_i),
      .reset_i       (reset_i),
      .port_pins_i   (port_pins_i),
      .pin_select_i  (ext_irq_pin_polarity_config[`EII_A_SEL_MSB:
                                                  `EII_A_SEL_LSB]),
      .polarity_i    (ext_irq_pin_polarity_config[`EII_A_POL_BIT]),
      .edge_select_i (irq_a_edge_select),
      .vector_ack_i  (vector_a_i),
      .sw_write_i    (sfr_wr_i & tmr_ctl_hit),
      .sw_value_i    (sfr_wdata_i[`EII_TMR_CTL_A_PEND]),
      .pending_o     (irq_a_pending)
   );

   eii_channel #(
      .PORT_WIDTH (PORT_WIDTH),
      .SEL_WIDTH  (SEL_WIDTH)
   ) u_chan_b (
      .ref_clk_i     (ref_clk_i),
      .reset_i       (reset_i),
      .port_pins_i   (port_pins_i),
      .pin_select_i  (ext_irq_pin_polarity_config[`EII_B_SEL_MSB:
                                                  `EII_B_SEL_LSB]),
      .polarity_i    (ext_irq_pin_polarity_config[`EII_B_POL_BIT]),
      .edge_select_i (irq_b_edge_select),
      .vector_ack_i  (vector_b_i),
      .sw_write_i    (sfr_wr_i & tmr_ctl_hit),
      .sw_value_i    (sfr_wdata_i[`EII_TMR_CTL_B_PEND]),
      .pending_o     (irq_b_pending)
   );

   // pending flags are the CPU requests, straight from flops
   assign irq_a_request_o = irq_a_pending;
   assign irq_b_request_o = irq_b_pending;

   ////////////////////////////////////////////////////////////////////////
   // Read side; timer bits of the shared register read zero here
   assign timer_control_reg = {4'h0, irq_b_pending, irq_b_edge_select,
                               irq_a_pending, irq_a_edge_select};

   always @* begin
      next_rdata = 8'h00;
      if (sfr_rd_i && cfg_hit)
         next_rdata = ext_irq_pin_polarity_config;
      else if (sfr_rd_i && tmr_ctl_hit)
         next_rdata = timer_control_reg;
   end

   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i)
         sfr_rdata_o <= 8'h00;
      else
         sfr_rdata_o <= next_rdata;
   end

endmodule

// ==== bench/eii_properties.sv ====
// Port assertions for the external interrupt inputs
`timescale 1ns/1ps
module eii_checker (
   input logic       ref_clk_i,
   input logic       reset_i,
   input logic [7:0] port_pins_i,
   input logic [7:0] sfr_addr_i,
   input logic [7:0] sfr_wdata_i,
   input logic       sfr_wr_i,
   input logic       sfr_rd_i,
   input logic       vector_a_i,
   input logic       vector_b_i,
   input logic [7:0] sfr_rdata_o,
   input logic       irq_a_request_o,
   input logic       irq_b_request_o
);
   logic [7:0] cfg;
   logic       ea, eb;
   wire act_a = port_pins_i[cfg[2:0]] == cfg[3];
   wire act_b = port_pins_i[cfg[6:4]] == cfg[7];
   wire rd_c = sfr_rd_i && sfr_addr_i == 8'hde;
   wire rd_t = sfr_rd_i && sfr_addr_i == 8'h88;
   // Shadow of software writes: whole config byte, and only the mode bits of timer control
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) {cfg, eb, ea} <= 10'h000;
      else if (sfr_wr_i && sfr_addr_i == 8'hde) cfg <= sfr_wdata_i;
      else if (sfr_wr_i && sfr_addr_i == 8'h88)
         {eb, ea} <= {sfr_wdata_i[2], sfr_wdata_i[0]};
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   sequence calm; (!ea && !eb && !sfr_wr_i) [*3]; endsequence
   sequence rise_a; ea && !sfr_wr_i && !act_a ##1 act_a && !sfr_wr_i
      ##1 !sfr_wr_i [*2]; endsequence
   AST_RD_CFG: assert property (rd_c |=> sfr_rdata_o == $past(cfg))
      else $error("config read");
   AST_RD_TMR_CTL: assert property (rd_t |=> sfr_rdata_o ==
      {4'h0, $past({irq_b_request_o, eb, irq_a_request_o, ea})})
      else $error("timer control read");
   AST_RD_IDLE: assert property (!rd_c && !rd_t |=> sfr_rdata_o == 8'h00)
      else $error("idle read data");
   AST_LEVEL_A: assert property (
      calm |=> irq_a_request_o == $past(act_a, 3)) else $error("level a");
   AST_LEVEL_B: assert property (
      calm |=> irq_b_request_o == $past(act_b, 3)) else $error("level b");
   AST_EDGE_A: assert property (rise_a |=> irq_a_request_o)
      else $error("edge a");
   AST_HOLD_B: assert property (
      eb && irq_b_request_o && !vector_b_i && !sfr_wr_i |=> irq_b_request_o)
      else $error("hold b");
   AST_CLEAR_B: assert property (
      eb && vector_b_i && !sfr_wr_i && $past(act_b, 2) == $past(act_b, 3)
      |=> !irq_b_request_o) else $error("clear b");
endmodule

// ==== bench/eii_source.sv ====
// Model of the interrupt sources on the port pins
`timescale 1ns/1ps
module eii_source (
   input  logic       ref_clk_i,
   input  logic       reset_i,
   input  logic       load_i,
   input  logic [7:0] drive_i,
   input  logic       served_i,
   output logic [7:0] pins_o
);
   // level held until served, then all eight pins inverted
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) pins_o <= 8'hff;
      else if (load_i) pins_o <= drive_i;
      else if (served_i) pins_o <= ~pins_o;
   end
endmodule

// ==== bench/eii_top_bench.sv ====
// Self-checking bench for the external interrupt inputs
`timescale 1ns/1ps
module eii_top_bench;
   logic ref_clk_i = 0, reset_i = 1, sfr_wr_i = 0, sfr_rd_i = 0, ld = 0;
   logic vector_a_i = 0, vector_b_i = 0, irq_a, irq_b;
   logic [7:0] sfr_addr_i = '0, sfr_wdata_i = '0, dv = '0, rdata, pins, p;
   int fail_count = 0, tests_run = 0;
   eii_top i_eii_top (.ref_clk_i, .reset_i, .port_pins_i(pins), .sfr_addr_i,
      .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .vector_a_i, .vector_b_i,
      .sfr_rdata_o(rdata), .irq_a_request_o(irq_a), .irq_b_request_o(irq_b));
   eii_source i_eii_source (.ref_clk_i, .reset_i, .load_i(ld), .drive_i(dv),
      .served_i(vector_a_i), .pins_o(pins));
   task chk(input logic [7:0] g, e);
      tests_run++;
      if (g !== e) begin
         $display("wrong value at %0t: %h expected %h", $time, g, e);
         fail_count++;
      end
   endtask
   task acc(input logic w, input logic [7:0] a, d);
      @(negedge ref_clk_i);
      {sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} = {w, !w, a, d};
      @(negedge ref_clk_i);
      {sfr_wr_i, sfr_rd_i} = 2'b00;
   endtask
   task drv(input logic [7:0] v);
      @(negedge ref_clk_i);
      {dv, ld} = {v, 1'b1};
      @(negedge ref_clk_i);
      ld = 0;
      repeat (4) @(negedge ref_clk_i);
   endtask
   task vec(input logic a, b);
      @(negedge ref_clk_i);
      {vector_a_i, vector_b_i} = {a, b};
      @(negedge ref_clk_i);
      {vector_a_i, vector_b_i} = 2'b00;
   endtask
   task complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial forever #5 ref_clk_i = ~ref_clk_i;
   initial begin
      repeat (10) @(negedge ref_clk_i);
      reset_i = 0;
      acc(0, 8'hde, 8'h00);
      chk(rdata, 8'h00);
      acc(1, 8'hde, 8'ha5);
      acc(0, 8'hde, 8'h00);
      chk(rdata, 8'ha5);
      acc(0, 8'h10, 8'h00);
      chk(rdata, 8'h00);
      for (int i = 0; i < 8; i++) begin
         acc(1, 8'hde, {i[1], 3'(7 - i), i[0], i[2:0]});
         for (int k = 0; k < 2; k++) begin
            p = k ? 8'h01 << i : ~(8'h01 << i);
            drv(p);
            chk({irq_a, irq_b}, {p[i] == i[0], p[7 - i] == i[1]});
         end
      end
      acc(1, 8'hde, 8'h90);
      drv(8'hfd);
      acc(1, 8'h88, 8'h05);
      drv(8'hfe);
      chk({irq_a, irq_b}, 8'h03);
      acc(0, 8'h88, 8'h00);
      chk(rdata, 8'h0f);
      drv(8'hff);
      vec(1, 0);
      chk({irq_a, irq_b}, 8'h01);
      vec(0, 1);
      chk({irq_a, irq_b}, 8'h00);
      acc(1, 8'h88, 8'h00);
      acc(1, 8'hde, 8'h0a);
      drv(8'h05);
      vec(1, 0);
      chk(irq_a, 8'h01);
      repeat (4) @(negedge ref_clk_i);
      chk(irq_a, 8'h00);
      complete_run;
   end
endmodule
bind eii_top eii_checker i_eii_checker (.*);
